// ==== logic/pbm_device.sv ====
`timescale 1ns/10ps
// How it works
// RQ1: Gate bit set: plane passes during on.
// RQ2: Gate bit set: plane zeroed during off.
// RQ3: Gate bit clear: plane always passes.
// RQ4: Blink timing comes from command rate bits.
// RQ5: Gate register bit0 on data line 0.
// RQ6: Probe register readable/writable anytime, uninitialised.
// RQ7: Writes touch low nibble; reads return eight.
// RQ8: Codes 4,2,1 give blue/green/red high nibble.
// RQ9: Codes C,A,9 give blue/green/red low nibble.
// RQ10: Host writes one-hot colour code, nibble bit.
// RQ11: Read shows nibble over old select code.
// RQ12: Pixels held steady during a probe read.
// RQ13: Inputs latched on load strobe rising edge.
// RQ14: Strobe is quarter/fifth rate, any phase.
// RQ15: Rate codes: 16/48,16/16,32/32,64/64 frames.
// RQ16: Planes ANDed with read mask first.
// RQ17: Same gating all ports; step per vsync.
module pbm_device
   import pbm_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   pbm_link_if.dev LINK,
   input wire logic [7:0] DAC_RED,
   input wire logic [7:0] DAC_GREEN,
   input wire logic [7:0] DAC_BLUE,
   output logic [PBM_PORTS*PBM_PIX_W-1:0] PAL_ADDR,
   output logic [PBM_PORTS*PBM_OVL_W-1:0] PAL_OVERLAY,
   output logic PAL_SYNC_N,
   output logic PAL_BLANK_N,
   output logic PAL_VALID,
   output logic BLINK_ON
);
   // All device state: the four software registers, the pixel latch,
   // the vertical period detector, the blink phase and the read answer.
   typedef struct packed {
      // Software registers, never reset.
      logic [7:0] read_mask;
      logic [7:0] blink_gate;
      logic [7:0] command;
      logic [7:0] probe;
      // Load edge detector and the latched pixel pipeline.
      logic strobe_prev;
      logic [PBM_PORTS*PBM_PIX_W-1:0] pal_addr;
      logic [PBM_PORTS*PBM_OVL_W-1:0] ovl;
      logic sync_n;
      logic blank_n;
      logic valid;
      // Vertical period detector and blink phase.
      logic [7:0] sync_low;
      logic [6:0] frame;
      logic blink_out;
      // Read answer back to the host end.
      logic [7:0] rdata;
      logic rvalid;
   } pbm_dev_state_t;

   pbm_dev_state_t s_q, s_d;
   logic [1:0] rate;
   logic [6:0] on_len;
   logic [7:0] period;
   logic blink_on;
   logic [7:0] plane_keep;
   logic load_rise;
   logic vsync_tick;
   logic [3:0] probe_nib;

   // Blink on length and period per rate select code. [RQ4] [RQ15]
   // An unwritten command register falls into the default, slowest rate.
   assign rate = {s_q.command[PBM_CMD_BLINK_HI], s_q.command[PBM_CMD_BLINK_LO]};
   always_comb begin
      case (rate)
         2'b00: begin
            on_len = PBM_ON_00;
            period = PBM_PER_00;
         end
         2'b01: begin
            on_len = PBM_ON_01;
            period = PBM_PER_01;
         end
         2'b10: begin
            on_len = PBM_ON_10;
            period = PBM_PER_10;
         end
         default: begin
            on_len = PBM_ON_11;
            period = PBM_PER_11;
         end
      endcase
   end

   // The blink phase is on for the first on_len vertical periods of each cycle.
   assign blink_on = s_q.frame < on_len;
   // Gated planes pass in the on phase, drop to zero otherwise. [RQ1] [RQ2] [RQ3]
   // A clear gate bit keeps its plane in both phases.
   assign plane_keep = blink_on ? 8'hFF : ~s_q.blink_gate;
   // The strobe comes from logic on CLK, so a registered copy gives its edge. [RQ14]
   // The copy resets low, the strobe's idle level, so no false edge follows reset.
   assign load_rise = LINK.load_strobe & ~s_q.strobe_prev;
   // Vertical sync ends when a long low sync run returns high. [RQ17]
   // Horizontal sync pulses are far shorter than the minimum run, so only the
   // vertical pulse can step the blink phase.
   assign vsync_tick = load_rise & LINK.sync_n & ~s_q.sync_n
      & (s_q.sync_low >= PBM_VSYNC_MIN_LOADS);

   // Probe nibble from the selected converter input. [RQ8] [RQ9]
   // Any other code, with no colour or several, reads a zero nibble.
   always_comb begin
      case (s_q.probe[3:0])
         PBM_PR_BLUE_MS: probe_nib = DAC_BLUE[7:4];
         PBM_PR_GREEN_MS: probe_nib = DAC_GREEN[7:4];
         PBM_PR_RED_MS: probe_nib = DAC_RED[7:4];
         PBM_PR_BLUE_LS: probe_nib = DAC_BLUE[3:0];
         PBM_PR_GREEN_LS: probe_nib = DAC_GREEN[3:0];
         PBM_PR_RED_LS: probe_nib = DAC_RED[3:0];
         default: probe_nib = 4'h0;
      endcase
   end

   // Next state: register writes and reads, pixel latch, blink counter.
   // Host writes and reads arrive as one-cycle pulses from the host end.
   always_comb begin
      s_d = s_q;
      s_d.strobe_prev = LINK.load_strobe;
      // Blink phase output is registered like the other data outputs.
      s_d.blink_out = blink_on;
      s_d.valid = 1'b0;
      s_d.rvalid = 1'b0;
      if (LINK.bus_wr) begin
         case (LINK.bus_addr)
            PBM_A_READ_MASK: s_d.read_mask = LINK.bus_wdata;
            PBM_A_BLINK_MASK: s_d.blink_gate = LINK.bus_wdata; // Bit n on line n. [RQ5]
            PBM_A_COMMAND: s_d.command = LINK.bus_wdata;
            default: s_d.probe[3:0] = LINK.bus_wdata[3:0]; // Low nibble only. [RQ7] [RQ6]
         endcase
      end
      if (LINK.bus_rd) begin
         // The answer stands on the link one cycle after the read pulse.
         s_d.rvalid = 1'b1;
         case (LINK.bus_addr)
            PBM_A_READ_MASK: s_d.rdata = s_q.read_mask;
            PBM_A_BLINK_MASK: s_d.rdata = s_q.blink_gate;
            PBM_A_COMMAND: s_d.rdata = s_q.command;
            default: s_d.rdata = {probe_nib, s_q.probe[3:0]}; // [RQ11] [RQ7]
         endcase
      end
      // Latch pixels, overlay, sync and blank on the strobe's rise. [RQ13]
      if (load_rise) begin
         s_d.valid = 1'b1;
         for (int p = 0; p < PBM_PORTS; p++) begin
            // Read mask AND, then blink gating, same on every port. [RQ16] [RQ17]
            s_d.pal_addr[p*PBM_PIX_W+:PBM_PIX_W] =
               LINK.pixel_plane_inputs[p*PBM_PIX_W+:PBM_PIX_W] & s_q.read_mask & plane_keep;
         end
         s_d.ovl = LINK.overlay_select;
         s_d.sync_n = LINK.sync_n;
         s_d.blank_n = LINK.blank_n;
         // Sync low runs are counted in loads and saturate rather than wrap.
         if (LINK.sync_n) begin
            s_d.sync_low = 8'h00;
         end else if (s_q.sync_low != 8'hFF) begin
            s_d.sync_low = s_q.sync_low + 8'h01;
         end
      end
      // One blink step per vertical period, wrapping at the period. [RQ17] [RQ15]
      // The wrap compares with at least, so a rate change mid-cycle never
      // leaves the counter stranded beyond the new period.
      if (vsync_tick) begin
         if ({1'b0, s_q.frame} >= period - 8'h01) begin
            s_d.frame = 7'h00;
         end else begin
            s_d.frame = s_q.frame + 7'h01;
         end
      end
      // Software registers keep no reset value; the pipeline does. [RQ5] [RQ6]
      // Pixel state and the blink phase restart; the registers wait for the host.
      if (RESET) begin
         s_d.strobe_prev = 1'b0;
         s_d.blink_out = 1'b0;
         s_d.pal_addr = '0;
         s_d.ovl = '0;
         s_d.sync_n = 1'b1;
         s_d.blank_n = 1'b1;
         s_d.valid = 1'b0;
         s_d.sync_low = 8'h00;
         s_d.frame = 7'h00;
         s_d.rdata = 8'h00;
         s_d.rvalid = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge CLK) begin
      s_q <= s_d;
   end

   // Outputs from registered state.
   assign PAL_ADDR = s_q.pal_addr;
   assign PAL_OVERLAY = s_q.ovl;
   assign PAL_SYNC_N = s_q.sync_n;
   assign PAL_BLANK_N = s_q.blank_n;
   assign PAL_VALID = s_q.valid;
   assign BLINK_ON = s_q.blink_out;
   // The read answer goes straight back over the link.
   assign LINK.bus_rdata = s_q.rdata;
   assign LINK.bus_rvalid = s_q.rvalid;
endmodule

// ==== logic/pbm_pkg.sv ====
package pbm_pkg;
   // Pixel ports multiplexed per load strobe, and their widths.
   localparam int PBM_PORTS = 5;
   localparam int PBM_PIX_W = 8;
   localparam int PBM_OVL_W = 2;
   // Device register addresses on the device's own parallel bus.
   localparam logic [1:0] PBM_A_READ_MASK = 2'h0;
   localparam logic [1:0] PBM_A_BLINK_MASK = 2'h1;
   localparam logic [1:0] PBM_A_COMMAND = 2'h2;
   localparam logic [1:0] PBM_A_PROBE = 2'h3;
   // Command register fields.
   localparam int PBM_CMD_BLINK_LO = 4;
   localparam int PBM_CMD_BLINK_HI = 5;
   localparam int PBM_CMD_MUX5 = 7;
   // Probe select field, nibble select bit and the six valid codes.
   localparam int PBM_PROBE_NIB = 3;
   localparam logic [3:0] PBM_PR_BLUE_MS = 4'h4;
   localparam logic [3:0] PBM_PR_GREEN_MS = 4'h2;
   localparam logic [3:0] PBM_PR_RED_MS = 4'h1;
   localparam logic [3:0] PBM_PR_BLUE_LS = 4'hC;
   localparam logic [3:0] PBM_PR_GREEN_LS = 4'hA;
   localparam logic [3:0] PBM_PR_RED_LS = 4'h9;
   // Blink on lengths and full periods, in vertical periods.
   localparam logic [6:0] PBM_ON_00 = 7'h10;
   localparam logic [7:0] PBM_PER_00 = 8'h40;
   localparam logic [6:0] PBM_ON_01 = 7'h10;
   localparam logic [7:0] PBM_PER_01 = 8'h20;
   localparam logic [6:0] PBM_ON_10 = 7'h20;
   localparam logic [7:0] PBM_PER_10 = 8'h40;
   localparam logic [6:0] PBM_ON_11 = 7'h40;
   localparam logic [7:0] PBM_PER_11 = 8'h80;
   // A sync low run of at least this many loads marks vertical sync.
   localparam logic [7:0] PBM_VSYNC_MIN_LOADS = 8'h40;
   // Load strobe divide ratios and the count at which the strobe falls.
   localparam logic [2:0] PBM_DIV4 = 3'h4;
   localparam logic [2:0] PBM_DIV5 = 3'h5;
   localparam logic [2:0] PBM_STROBE_HIGH = 3'h2;
   // Host video register after reset: overlay zero, sync and blank inactive.
   localparam logic [3:0] PBM_VIDEO_RESET = 4'hC;
   // Host controller Avalon byte offsets and fields.
   localparam logic [4:0] PBM_H_ACCESS = 5'h00;
   localparam logic [4:0] PBM_H_STATUS = 5'h04;
   localparam logic [4:0] PBM_H_LOAD = 5'h08;
   localparam logic [4:0] PBM_H_PIXEL = 5'h0C;
   localparam logic [4:0] PBM_H_VIDEO = 5'h10;
   localparam int PBM_ACC_ADDR_LO = 8;
   localparam int PBM_ACC_READ = 10;
   localparam int PBM_LOAD_RUN = 0;
   localparam int PBM_LOAD_MUX5 = 1;
   localparam int PBM_VID_SYNC_N = 2;
   localparam int PBM_VID_BLANK_N = 3;
endpackage

// ==== logic/pbm_link_if.sv ====
`timescale 1ns/10ps
interface pbm_link_if;
   import pbm_pkg::*;
   logic load_strobe;
   logic [PBM_PORTS*PBM_PIX_W-1:0] pixel_plane_inputs;
   logic [PBM_PORTS*PBM_OVL_W-1:0] overlay_select;
   logic sync_n;
   logic blank_n;
   logic [1:0] bus_addr;
   logic [7:0] bus_wdata;
   logic bus_wr;
   logic bus_rd;
   logic [7:0] bus_rdata;
   logic bus_rvalid;
   modport dev (input load_strobe, pixel_plane_inputs, overlay_select, sync_n, blank_n,
      bus_addr, bus_wdata, bus_wr, bus_rd, output bus_rdata, bus_rvalid);
   modport host (output load_strobe, pixel_plane_inputs, overlay_select, sync_n, blank_n,
      bus_addr, bus_wdata, bus_wr, bus_rd, input bus_rdata, bus_rvalid);
endinterface

// ==== logic/pbm_host.sv ====
`timescale 1ns/10ps
// Host side: an Avalon slave that runs device register accesses and
// sources the pixel stream with a divided load strobe.
module pbm_host
   import pbm_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   pbm_link_if.host LINK
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic busy;
      logic wr;
      logic rd;
      logic [1:0] addr;
      logic [7:0] wdata;
      logic [7:0] last_rd;
      logic [1:0] load_cfg;
      logic [7:0] pixel;
      logic [3:0] video;
      logic [2:0] div;
      logic [PBM_PORTS*PBM_PIX_W-1:0] pix_out;
      logic [PBM_PORTS*PBM_OVL_W-1:0] ovl_out;
      logic sync_n;
      logic blank_n;
   } pbm_host_state_t;

   pbm_host_state_t s_q, s_d;
   logic wr_ok;
   logic [2:0] div_top;

   // Writes stall while a device access runs so pixel data stays fixed. [RQ12]
   assign wr_ok = AVS_WRITE & ~s_q.busy;
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_q.ack;
   assign AVS_READDATA = s_q.rdata;
   assign div_top = s_q.load_cfg[PBM_LOAD_MUX5] ? PBM_DIV5 : PBM_DIV4;

   // Next state of the bus slave, access engine and pixel source.
   always_comb begin
      s_d = s_q;
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      s_d.ack = (AVS_READ | wr_ok) & ~s_q.ack;
      if (s_d.ack && AVS_READ) begin
         case (AVS_ADDRESS)
            PBM_H_STATUS: s_d.rdata = {16'h0000, s_q.last_rd, 7'h00, s_q.busy};
            PBM_H_LOAD: s_d.rdata = {30'h0, s_q.load_cfg};
            PBM_H_PIXEL: s_d.rdata = {24'h000000, s_q.pixel};
            PBM_H_VIDEO: s_d.rdata = {28'h0000000, s_q.video};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      if (AVS_WRITE && s_q.ack) begin
         case (AVS_ADDRESS)
            PBM_H_ACCESS: begin
               s_d.busy = 1'b1;
               s_d.addr = AVS_WRITEDATA[PBM_ACC_ADDR_LO+:2];
               s_d.wdata = AVS_WRITEDATA[7:0];
               s_d.rd = AVS_WRITEDATA[PBM_ACC_READ];
               s_d.wr = ~AVS_WRITEDATA[PBM_ACC_READ];
            end
            PBM_H_LOAD: s_d.load_cfg = AVS_WRITEDATA[1:0];
            PBM_H_PIXEL: s_d.pixel = AVS_WRITEDATA[7:0];
            PBM_H_VIDEO: s_d.video = AVS_WRITEDATA[3:0];
            default: s_d.busy = s_q.busy;
         endcase
      end
      // A write finishes at once; a read finishes when the answer returns.
      if (s_q.wr) begin
         s_d.busy = 1'b0;
      end
      if (LINK.bus_rvalid) begin
         s_d.last_rd = LINK.bus_rdata;
         s_d.busy = 1'b0;
      end
      // Divider for the load strobe at one quarter or one fifth of CLK. [RQ14]
      if (!s_q.load_cfg[PBM_LOAD_RUN] || s_q.div >= div_top - 3'h1) begin
         s_d.div = 3'h0;
      end else begin
         s_d.div = s_q.div + 3'h1;
      end
      // Pixel data changes only while the strobe is low, away from its rise. [RQ13]
      if (s_q.div == PBM_STROBE_HIGH) begin
         s_d.pix_out = {PBM_PORTS{s_q.pixel}};
         s_d.ovl_out = {PBM_PORTS{s_q.video[1:0]}};
         s_d.sync_n = s_q.video[PBM_VID_SYNC_N];
         s_d.blank_n = s_q.video[PBM_VID_BLANK_N];
      end
      if (RESET) begin
         s_d = '0;
         s_d.sync_n = 1'b1;
         s_d.blank_n = 1'b1;
         s_d.video = PBM_VIDEO_RESET;
      end
   end

   // State register.
   always_ff @(posedge CLK) begin
      s_q <= s_d;
   end

   // Link drive from registered state.
   assign LINK.load_strobe = s_q.load_cfg[PBM_LOAD_RUN] & (s_q.div < PBM_STROBE_HIGH);
   assign LINK.pixel_plane_inputs = s_q.pix_out;
   assign LINK.overlay_select = s_q.ovl_out;
   assign LINK.sync_n = s_q.sync_n;
   assign LINK.blank_n = s_q.blank_n;
   assign LINK.bus_addr = s_q.addr;
   assign LINK.bus_wdata = s_q.wdata;
   assign LINK.bus_wr = s_q.wr; // Host loads the probe code before reading. [RQ10] [RQ11]
   assign LINK.bus_rd = s_q.rd;
endmodule

// ==== tb/pbm_link_checker.sv ====
`timescale 1ns/10ps
// Watches the link between the host end and the device end.
module pbm_link_checker
   import pbm_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic load_strobe,
   input wire logic [PBM_PORTS*PBM_PIX_W-1:0] pixel_plane_inputs,
   input wire logic [1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_rvalid
);
   typedef struct packed {
      logic [3:0] code;
      logic code_ok;
      logic [7:0] gate;
      logic gate_ok;
   } pbm_sh_t;
   pbm_sh_t st_q;
   pbm_sh_t st_d;
   // Shadows the last probe code and gate value written, known only once written.
   always_comb begin
      st_d = st_q;
      if (bus_wr && bus_addr == PBM_A_PROBE) begin
         st_d.code = bus_wdata[3:0];
         st_d.code_ok = 1'b1;
      end
      if (bus_wr && bus_addr == PBM_A_BLINK_MASK) begin
         st_d.gate = bus_wdata;
         st_d.gate_ok = 1'b1;
      end
      if (RESET) begin
         st_d.code_ok = 1'b0;
         st_d.gate_ok = 1'b0;
      end
   end
   // Registers the shadow copy.
   always_ff @(posedge CLK) begin
      st_q <= st_d;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_probe_read;
      bus_rd && bus_addr == PBM_A_PROBE && st_q.code_ok;
   endsequence
   sequence s_rise;
      $rose(load_strobe);
   endsequence
   a_read_answer: assert property (bus_rd |=> bus_rvalid)
      else $error("device read got no answer");
   a_valid_cause: assert property (bus_rvalid |-> $past(bus_rd))
      else $error("answer without a read");
   a_rd_wr_excl: assert property (!(bus_rd && bus_wr))
      else $error("read and write together");
   a_probe_code: assert property (s_probe_read |=> bus_rdata[3:0] == st_q.code)
      else $error("probe low nibble lost");
   a_gate_readback: assert property (
      bus_rd && bus_addr == PBM_A_BLINK_MASK && st_q.gate_ok |=> bus_rdata == st_q.gate)
      else $error("gate read back wrong");
   a_pixel_hold: assert property (s_rise |-> $stable(pixel_plane_inputs))
      else $error("pixels moved at load");
   a_strobe_high: assert property (s_rise |=> load_strobe ##1 !load_strobe)
      else $error("strobe width wrong");
   a_strobe_period: assert property (s_rise |=>
      (!$rose(load_strobe)) [*3] ##[1:2] s_rise)
      else $error("strobe period wrong");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
// Drives both ends through the host Avalon port and checks the palette outputs.
module testbench;
   import pbm_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] av_addr = 5'h00;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wdata = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic [7:0] red = 8'h00;
   logic [7:0] green = 8'h00;
   logic [7:0] blue = 8'h00;
   logic [39:0] pal_addr;
   logic [9:0] pal_ovl;
   logic pal_sync_n;
   logic pal_blank_n;
   logic pal_valid;
   logic blink_on;
   logic [31:0] q;
   logic [7:0] mask;
   logic [7:0] gate;
   logic [7:0] pix;
   logic [1:0] ov;
   int bad_count = 0;
   int n_tests = 0;
   int seed = 32'h0E782448;
   int frame = 0;
   int on_len[4] = '{PBM_ON_00, PBM_ON_01, PBM_ON_10, PBM_ON_11};
   int per_len[4] = '{PBM_PER_00, PBM_PER_01, PBM_PER_10, PBM_PER_11};
   int n_fr[4] = '{50, 34, 34, 66};
   logic [3:0] codes[7] = '{PBM_PR_BLUE_MS, PBM_PR_GREEN_MS, PBM_PR_RED_MS, PBM_PR_BLUE_LS,
      PBM_PR_GREEN_LS, PBM_PR_RED_LS, 4'h3};
   pbm_link_if link ();
   pbm_host i_pbm_host (.CLK(clk), .RESET(reset), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
      .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata),
      .AVS_WAITREQUEST(av_wait), .LINK(link.host));
   pbm_device i_pbm_device (.CLK(clk), .RESET(reset), .LINK(link.dev), .DAC_RED(red),
      .DAC_GREEN(green), .DAC_BLUE(blue), .PAL_ADDR(pal_addr), .PAL_OVERLAY(pal_ovl),
      .PAL_SYNC_N(pal_sync_n), .PAL_BLANK_N(pal_blank_n), .PAL_VALID(pal_valid),
      .BLINK_ON(blink_on));
   pbm_link_checker i_chk (.CLK(clk), .RESET(reset), .load_strobe(link.load_strobe),
      .pixel_plane_inputs(link.pixel_plane_inputs), .bus_addr(link.bus_addr),
      .bus_wdata(link.bus_wdata), .bus_wr(link.bus_wr), .bus_rd(link.bus_rd),
      .bus_rdata(link.bus_rdata), .bus_rvalid(link.bus_rvalid));
   // Makes the 8 ns clock.
   always begin
      #4 clk = ~clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Counts a used-up wait and closes the run.
   task automatic tmo(input logic hit);
      if (hit) begin
         bad_count++;
         $display("mismatch at %0t: wait ran out", $time);
         complete_run();
      end
   endtask
   // One Avalon access, held until waitrequest is seen low.
   task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (av_wait !== 1'b0 && n < 40);
      q = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      tmo(n >= 40);
   endtask
   // Starts a device register access and polls until the host is idle.
   task automatic dev(input logic rd, input logic [1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      av(PBM_H_ACCESS, 1'b1, {21'h0, rd, a, d});
      do begin
         av(PBM_H_STATUS, 1'b0, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 20);
      tmo(n >= 20);
   endtask
   // Waits for a number of palette loads.
   task automatic loads(input int n);
      int k;
      k = 0;
      while (n > 0 && k < 4000) begin
         @(negedge clk);
         k++;
         if (pal_valid === 1'b1) n--;
      end
      tmo(n > 0);
   endtask
   // Expected probe read for a select code.
   function automatic logic [7:0] exp_probe(input logic [3:0] c);
      case (c)
         PBM_PR_BLUE_MS: return {blue[7:4], c};
         PBM_PR_GREEN_MS: return {green[7:4], c};
         PBM_PR_RED_MS: return {red[7:4], c};
         PBM_PR_BLUE_LS: return {blue[3:0], c};
         PBM_PR_GREEN_LS: return {green[3:0], c};
         PBM_PR_RED_LS: return {red[3:0], c};
         default: return {4'h0, c};
      endcase
   endfunction
   // Expected palette address byte: read mask first, then blink gating.
   function automatic logic [7:0] exp_addr(input logic on);
      return pix & mask & (on ? 8'hFF : ~gate);
   endfunction
   // Main sequence: probe codes, then every blink rate over many frames.
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      red <= 8'($random(seed));
      green <= 8'($random(seed));
      blue <= 8'($random(seed));
      for (int i = 0; i < 7; i++) begin
         dev(1'b0, PBM_A_PROBE, {4'($random(seed)), codes[i]});
         dev(1'b1, PBM_A_PROBE, 8'h00);
         `CHK(q[15:8], exp_probe(codes[i]))
      end
      av(5'h14, 1'b0, 32'h0);
      `CHK(q, 32'h0)
      for (int r = 3; r >= 0; r--) begin
         mask = (r == 3) ? 8'hFF : 8'($random(seed));
         gate = (r == 2) ? 8'h00 : 8'($random(seed));
         dev(1'b0, PBM_A_READ_MASK, mask);
         dev(1'b0, PBM_A_BLINK_MASK, gate);
         dev(1'b1, PBM_A_BLINK_MASK, 8'h00);
         `CHK(q[15:8], gate)
         dev(1'b0, PBM_A_COMMAND, {r[0], 1'b1, 2'(r), 4'h0});
         dev(1'b1, PBM_A_COMMAND, 8'h00);
         `CHK(q[15:8], {r[0], 1'b1, 2'(r), 4'h0})
         av(PBM_H_LOAD, 1'b1, {30'h0, r[0], 1'b1});
         for (int f = 0; f < n_fr[r]; f++) begin
            ov = 2'($random(seed));
            av(PBM_H_VIDEO, 1'b1, {28'h0, 2'b10, ov});
            loads(66);
            `CHK({pal_sync_n, pal_blank_n, pal_ovl}, {2'b01, {5{ov}}})
            av(PBM_H_VIDEO, 1'b1, 32'hC);
            loads(2);
            frame = (frame >= per_len[r] - 1) ? 0 : frame + 1;
            pix = 8'($random(seed));
            av(PBM_H_PIXEL, 1'b1, {24'h0, pix});
            loads(3);
            `CHK(blink_on, frame < on_len[r])
            `CHK(pal_addr, {5{exp_addr(frame < on_len[r])}})
         end
      end
      complete_run();
   end
endmodule
